// [fab_host.sv]
/*
 * Host controller driving a NOR flash die over its asynchronous pins.
 * Turns user requests into read, command write, sector-group protect
 * and hardware reset cycles, timing page hits with the shorter delay.
 * Assumes the flash pins and ready_busy_n are synchronous to clk_sys.
 */
`timescale 1ns/1ns
`default_nettype none

module fab_host
    import fab_pkg::*;
#(
    parameter int FULL_CYC  = FULL_DELAY_CYC,
    parameter int PAGE_CYC  = PAGE_DELAY_CYC,
    parameter int RESET_CYC = RESET_PULSE_CYC
) (
    // System
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // User request side
    input  wire logic               req_valid,
    input  wire fab_req_t           req,
    input  wire logic               write_protect_on,
    input  wire logic               accel_on,
    output logic                    req_ready,
    output logic                    rsp_valid,
    output logic [DATA_W-1:0]       rsp_data,
    output logic                    flash_busy,
    // Flash pins
    output fab_ctrl_t               ctrl,
    output logic [ADDR_W-1:0]       addr_out,
    output logic [DATA_W-1:0]       data_out,
    output logic                    data_oe,
    input  wire logic [DATA_W-1:0]  data_in,
    input  wire logic               ready_busy_n
);

    ////////////////////////////////////////////////////////////////////////
    localparam fab_ctrl_t CTRL_IDLE = '{chip_sel_n: 1'b1, out_gate_n: 1'b1,
        wr_strobe_n: 1'b1, hw_reset_n: 1'b1, reset_id_level: 1'b0,
        protect_accelerate_pin: 1'b1, accelerate_level: 1'b0};

    fab_state_t              state_reg, state_next;
    fab_ctrl_t               ctrl_reg, ctrl_next;
    fab_req_t                cur_reg, cur_next;
    logic [ADDR_W-1:0]       addr_reg, addr_next;
    logic [DATA_W-1:0]       dout_reg, dout_next;
    logic                    oe_reg, oe_next;
    logic                    rdy_reg, rdy_next;
    logic                    rv_reg, rv_next;
    logic [DATA_W-1:0]       rdata_reg, rdata_next;
    logic [15:0]             cnt_reg, cnt_next;
    logic                    page_open_reg, page_open_next;
    logic [ADDR_W-1:WORD_SEL_W] page_reg, page_next;
    logic                    busy_reg, busy_next;
    logic                    page_hit;

    assign page_hit = page_open_reg && (page_reg == req.addr[ADDR_W-1:WORD_SEL_W]);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next     = state_reg;
        ctrl_next      = ctrl_reg;
        cur_next       = cur_reg;
        addr_next      = addr_reg;
        dout_next      = dout_reg;
        oe_next        = oe_reg;
        rdy_next       = rdy_reg;
        rv_next        = 1'b0;
        rdata_next     = rdata_reg;
        cnt_next       = cnt_reg;
        page_open_next = page_open_reg;
        page_next      = page_reg;
        busy_next      = !ready_busy_n;
        // Low keeps the end sector locked; the accelerate level overrides it.
        ctrl_next.protect_accelerate_pin = !write_protect_on || accel_on;
        ctrl_next.accelerate_level = accel_on;
        // A protect cycle keeps the pin high for its whole strobe, whatever the request.
        if (ctrl_reg.reset_id_level) begin
            ctrl_next.protect_accelerate_pin = 1'b1;
        end
        case (state_reg)
            FAB_IDLE: begin
                if (req_valid && rdy_reg) begin
                    cur_next  = req;
                    rdy_next  = 1'b0;
                    addr_next = req.addr;
                    state_next = FAB_SETUP;
                    case (req.op)
                        FAB_OP_READ: begin
                            // Holding select low keeps the page open; a read into the
                            // same page waits only the short delay.
                            ctrl_next.chip_sel_n  = 1'b0;
                            ctrl_next.out_gate_n  = 1'b0;
                            ctrl_next.wr_strobe_n = 1'b1;
                            oe_next  = 1'b0;
                            cnt_next = 16'(page_hit ? PAGE_CYC : FULL_CYC);
                            page_open_next = 1'b1;
                            page_next = req.addr[ADDR_W-1:WORD_SEL_W];
                            state_next = FAB_WAIT;
                        end
                        FAB_OP_RESET: begin
                            ctrl_next = CTRL_IDLE;
                            ctrl_next.hw_reset_n = 1'b0;
                            oe_next  = 1'b0;
                            cnt_next = 16'(RESET_CYC);
                            page_open_next = 1'b0;
                            state_next = FAB_RST;
                        end
                        default: begin
                            // Writes pass through deselect so any open page ends.
                            ctrl_next.chip_sel_n = 1'b1;
                            ctrl_next.out_gate_n = 1'b1;
                            page_open_next = 1'b0;
                            oe_next = 1'b0;
                        end
                    endcase
                end
            end
            FAB_SETUP: begin
                ctrl_next.chip_sel_n  = 1'b0;
                ctrl_next.out_gate_n  = 1'b1;
                ctrl_next.wr_strobe_n = 1'b0;
                dout_next = cur_reg.wdata;
                oe_next   = 1'b1;
                if (cur_reg.op == FAB_OP_PROTECT || cur_reg.op == FAB_OP_UNPROT) begin
                    ctrl_next.reset_id_level = 1'b1;
                    ctrl_next.protect_accelerate_pin = 1'b1;
                    addr_next = '0;
                    addr_next[ADDR_W-1:SECTOR_LSB] = cur_reg.addr[ADDR_W-1:SECTOR_LSB];
                    addr_next[PROT_BIT_A1] = 1'b1;
                    addr_next[PROT_BIT_A6] = (cur_reg.op == FAB_OP_UNPROT);
                end
                cnt_next   = 16'(FULL_CYC);
                state_next = FAB_WAIT;
            end
            FAB_WAIT: begin
                if (cnt_reg > 16'h1) begin
                    cnt_next = cnt_reg - 16'h1;
                end else begin
                    if (cur_reg.op == FAB_OP_READ) begin
                        rdata_next = data_in;
                        rv_next    = 1'b1;
                    end else begin
                        ctrl_next.wr_strobe_n    = 1'b1;
                        ctrl_next.chip_sel_n     = 1'b1;
                        ctrl_next.reset_id_level = 1'b0;
                        rv_next = 1'b1;
                    end
                    state_next = FAB_DONE;
                end
            end
            FAB_DONE: begin
                oe_next    = 1'b0;
                ctrl_next.out_gate_n = 1'b1;
                rdy_next   = 1'b1;
                state_next = FAB_IDLE;
            end
            FAB_RST: begin
                if (cnt_reg > 16'h1) begin
                    cnt_next = cnt_reg - 16'h1;
                end else begin
                    ctrl_next.hw_reset_n = 1'b1;
                    rv_next    = 1'b1;
                    state_next = FAB_DONE;
                end
            end
            default: state_next = FAB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_reg     <= FAB_IDLE;
            ctrl_reg      <= CTRL_IDLE;
            cur_reg       <= '0;
            addr_reg      <= '0;
            dout_reg      <= '0;
            oe_reg        <= 1'b0;
            rdy_reg       <= 1'b1;
            rv_reg        <= 1'b0;
            rdata_reg     <= '0;
            cnt_reg       <= '0;
            page_open_reg <= 1'b0;
            page_reg      <= '0;
            busy_reg      <= 1'b0;
        end else begin
            state_reg     <= state_next;
            ctrl_reg      <= ctrl_next;
            cur_reg       <= cur_next;
            addr_reg      <= addr_next;
            dout_reg      <= dout_next;
            oe_reg        <= oe_next;
            rdy_reg       <= rdy_next;
            rv_reg        <= rv_next;
            rdata_reg     <= rdata_next;
            cnt_reg       <= cnt_next;
            page_open_reg <= page_open_next;
            page_reg      <= page_next;
            busy_reg      <= busy_next;
        end
    end

    assign req_ready  = rdy_reg;
    assign rsp_valid  = rv_reg;
    assign rsp_data   = rdata_reg;
    assign flash_busy = busy_reg;
    assign ctrl       = ctrl_reg;
    assign addr_out   = addr_reg;
    assign data_out   = dout_reg;
    assign data_oe    = oe_reg;

    ////////////////////////////////////////////////////////////////////////
    sequence read_drive_s;
        !ctrl_reg.chip_sel_n && !ctrl_reg.out_gate_n;
    endsequence

    read_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        read_drive_s |-> ctrl_reg.wr_strobe_n && !oe_reg)
        else $error("read gate low while strobe or data driven");
    write_pins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl_reg.wr_strobe_n |-> !ctrl_reg.chip_sel_n && ctrl_reg.out_gate_n && oe_reg)
        else $error("write strobe without select, gate high and data driven");
    reset_float_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl_reg.hw_reset_n |-> !oe_reg && ctrl_reg.chip_sel_n)
        else $error("data driven during flash reset");
    protect_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_reg.reset_id_level |-> addr_reg[PROT_BIT_A1] && !addr_reg[0]
        && ctrl_reg.protect_accelerate_pin)
        else $error("protect cycle with wrong address or pin");
    page_fast_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == FAB_IDLE && req_valid && rdy_reg && req.op == FAB_OP_READ
        && page_hit |=> cnt_reg == 16'(PAGE_CYC))
        else $error("page hit not given short delay");
    page_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(ctrl_reg.chip_sel_n) |-> !page_open_reg || state_reg == FAB_IDLE)
        else $error("page left open across deselect");

endmodule // fab_host

`default_nettype wire

// [fab_pkg.sv]
/*
 * Package for the host-side controller of an asynchronous NOR flash bus.
 * Holds pin bundles, operation codes, address layout and access timing.
 * Assumes a single 10 MHz system clock.
 */
package fab_pkg;

    localparam int          CLK_PERIOD_NS     = 100;
    // Longest access times and the reset pulse width of the flash, in ns.
    localparam int          FULL_DELAY_NS     = 105;
    localparam int          PAGE_DELAY_NS     = 25;
    localparam int          RESET_PULSE_NS    = 500;
    // Least wait times round up to whole cycles, never below one.
    localparam int          FULL_DELAY_CYC    = (FULL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PAGE_DELAY_CYC    = (PAGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RESET_PULSE_CYC   = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int          ADDR_W            = 23;
    localparam int          DATA_W            = 16;
    localparam int          WORD_SEL_W        = 2;
    localparam int          SECTOR_LSB        = 15;
    localparam int          PROT_BIT_A6       = 6;
    localparam int          PROT_BIT_A1       = 1;

    typedef enum logic [2:0] {
        FAB_OP_READ    = 3'h0,
        FAB_OP_WRITE   = 3'h1,
        FAB_OP_PROTECT = 3'h2,
        FAB_OP_UNPROT  = 3'h3,
        FAB_OP_RESET   = 3'h4
    } fab_op_t;

    // Gray-coded along idle -> setup -> wait -> done.
    typedef enum logic [2:0] {
        FAB_IDLE  = 3'b000,
        FAB_SETUP = 3'b001,
        FAB_WAIT  = 3'b011,
        FAB_DONE  = 3'b010,
        FAB_RST   = 3'b110
    } fab_state_t;

    typedef struct packed {
        logic                chip_sel_n;
        logic                out_gate_n;
        logic                wr_strobe_n;
        logic                hw_reset_n;
        logic                reset_id_level;
        logic                protect_accelerate_pin;
        logic                accelerate_level;
    } fab_ctrl_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        fab_op_t             op;
    } fab_req_t;

endpackage

// [fab_flash_model.sv]
/*
 * Behavioural model of the flash die seen from its pins: array read,
 * hidden command latch, ready/busy and release of the data pins.
 * Assumes the host changes its pins just after rising clk_sys edges.
 */
`timescale 1ns/1ns
`default_nettype none

module fab_flash_model
    import fab_pkg::*;
(
    // Clock
    input  wire logic              clk_sys,
    // Pins from the host
    input  wire fab_ctrl_t         ctrl,
    input  wire logic [ADDR_W-1:0] addr_out,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe,
    // Pins to the host
    output logic [DATA_W-1:0]      data_in,
    output logic                   ready_busy_n
);
    logic [DATA_W-1:0] last_reg = 16'h0;
    logic [2:0]        busy_reg = 3'h0;
    fab_req_t          cmd_reg;
    logic              drive;

    // Array read needs no command and commands never alter it.
    assign drive = !ctrl.chip_sel_n && !ctrl.out_gate_n && ctrl.wr_strobe_n
        && ctrl.hw_reset_n && !data_oe;
    // A released bus shows the inverse of its last value, never a stale copy.
    assign data_in = drive ? (addr_out[15:0] ^ 16'h3c5a) : ~last_reg;
    assign ready_busy_n = (busy_reg == 3'h0);

    always_ff @(posedge clk_sys) begin
        last_reg <= data_in;
        if (!ctrl.hw_reset_n) begin
            busy_reg <= 3'h0;
        end else if (!ctrl.chip_sel_n && !ctrl.wr_strobe_n) begin
            cmd_reg  <= '{addr_out, data_out, FAB_OP_WRITE};
            busy_reg <= 3'h4;
        end else if (busy_reg != 3'h0) begin
            busy_reg <= busy_reg - 3'h1;
        end
    end
endmodule // fab_flash_model

`default_nettype wire

// [fab_host_test.sv]
/*
 * Self-checking bench for the flash host controller.
 * Assumes fab_flash_model stands on the pins and the defaults of fab_pkg.
 */
`timescale 1ns/1ns
`default_nettype none

module fab_host_test;
    import fab_pkg::*;
    localparam int F = 2;
    localparam int P = 1;
    localparam int R = 5;
    logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    logic wp_on = 1'b0, acc_on = 1'b0;
    fab_req_t req = '0;
    logic req_ready, rsp_valid, flash_busy, data_oe, ready_busy_n;
    logic [DATA_W-1:0] rsp_data, data_out, data_in, st_data, rd;
    logic [ADDR_W-1:0] addr_out, st_addr;
    fab_ctrl_t ctrl, st_ctrl;
    logic st_oe, rst_seen, busy_seen;
    int errors = 0, checked = 0, cyc = 0, lat;

    initial forever #50 clk_sys = ~clk_sys;

    fab_host #(.FULL_CYC(F), .PAGE_CYC(P), .RESET_CYC(R)) fab_host_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .write_protect_on(wp_on), .accel_on(acc_on), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .flash_busy(flash_busy),
        .ctrl(ctrl), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .ready_busy_n(ready_busy_n));
    fab_flash_model fab_flash_model_inst (
        .clk_sys(clk_sys), .ctrl(ctrl), .addr_out(addr_out), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .ready_busy_n(ready_busy_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Holds the request until taken, then counts cycles to the answer.
    task automatic issue(input fab_op_t op, input logic [22:0] a, input logic [15:0] d);
        rst_seen = 1'b0;
        busy_seen = 1'b0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{a, d, op};
        #1;
        // Ready is looked at between edges; the edge after it is seen high takes the request.
        while (req_ready !== 1'b1) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        req_valid <= 1'b0;
        lat = 0;
        do begin
            @(posedge clk_sys);
            #1;
            lat++;
            if (ctrl.wr_strobe_n === 1'b0) begin
                st_ctrl = ctrl;
                st_addr = addr_out;
                st_data = data_out;
                st_oe = data_oe;
            end
            if (ctrl.hw_reset_n === 1'b0) rst_seen = 1'b1;
            if (flash_busy === 1'b1) busy_seen = 1'b1;
        end while (rsp_valid !== 1'b1 && lat < 40);
        rd = rsp_data;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        check({ctrl.chip_sel_n, ctrl.hw_reset_n, req_ready, data_oe}, 4'he);
    endtask

    task automatic t_page();
        logic [22:0] a[4] = '{23'h001230, 23'h001233, 23'h001234, 23'h001235};
        int el[4] = '{F, P, F, P};
        for (int i = 0; i < 4; i++) begin
            issue(FAB_OP_READ, a[i], 16'h0);
            check(lat, el[i]);
            check(rd, a[i][15:0] ^ 16'h3c5a);
        end
    endtask

    task automatic t_write();
        issue(FAB_OP_WRITE, 23'h000555, 16'h00aa);
        check(lat, F + 1);
        check({st_ctrl.chip_sel_n, st_ctrl.out_gate_n, st_oe}, 3'h3);
        check(st_addr, 23'h000555);
        check(st_data, 16'h00aa);
        check(fab_flash_model_inst.cmd_reg.addr, 23'h000555);
        issue(FAB_OP_READ, 23'h000556, 16'h0);
        check(busy_seen, 1'b1);
        check(lat, F);
        check(rd, 16'h0556 ^ 16'h3c5a);
    endtask

    task automatic t_prot();
        fab_op_t ops[2] = '{FAB_OP_PROTECT, FAB_OP_UNPROT};
        // The lock request stays on, so only the cycle itself can lift the pin.
        @(posedge clk_sys);
        wp_on <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            issue(ops[i], 23'h3affff, 16'h0);
            check(lat, F + 1);
            check(st_addr[22:15], 8'h75);
            check({st_addr[6], st_addr[3:0]}, {i[0], 4'h2});
            check({st_ctrl.reset_id_level, st_ctrl.protect_accelerate_pin}, 2'h3);
        end
        @(posedge clk_sys);
        wp_on <= 1'b0;
    endtask

    task automatic t_rst();
        issue(FAB_OP_RESET, 23'h0, 16'h0);
        check({rst_seen, lat[3:0]}, {1'b1, 4'(R)});
        issue(FAB_OP_READ, 23'h000557, 16'h0);
        check(lat, F);
        check(rd, 16'h0557 ^ 16'h3c5a);
    endtask

    task automatic t_pins();
        @(posedge clk_sys);
        wp_on <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check(ctrl.protect_accelerate_pin, 1'b0);
        @(posedge clk_sys);
        wp_on <= 1'b0;
        acc_on <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check({ctrl.accelerate_level, ctrl.protect_accelerate_pin}, 2'h3);
        @(posedge clk_sys);
        acc_on <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // The ceiling is well above the fewer than one hundred cycles the scenarios take.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_idle();
        t_page();
        t_write();
        t_prot();
        t_rst();
        t_pins();
        conclude();
    end
endmodule // fab_host_test

`default_nettype wire
